// [core/lane_check_pkg.sv]
/*
 * constants, field layout and register map of the lane capture
 * and sample check block.
 * assumes byte-wide register access at the listed offsets.
 */
// Functional notes
// R01: software trigger rising 0 to 1 stores selected lane data in snapshot.
// R02: snapshot is 40 bits, read only, five byte registers, lowest first.
// R03: check control bits 7:4 pick sample 0 to 15 of chosen converter.
// R04: check control bits 3:2 pick converter channel 0 to 3.
// R05: check clear bit 1 held high resets the check result.
// R06: check runs only while enable bit 0 is one.
// R07: writable byte holds low byte of expected sample for compare.
// R08: all control fields, reference bytes and snapshot bytes reset to zero.
// R09: three-bit lane select picks one of eight lanes for capture.
// R10: capture source zero uses software trigger, one uses bit error.
// R11: second writable byte holds upper byte of expected sample.
// R12: read-only mismatch flag, zero on match, one on difference.
// R13: mismatch flag stays set while enabled until clear is asserted.
package lane_check_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 8;
  localparam int LANE_COUNT  = 8;
  localparam int LANE_W      = 40;
  localparam int LANE_SEL_W  = 3;
  localparam int CONV_COUNT  = 4;
  localparam int CONV_SEL_W  = 2;
  localparam int SAMPLE_CNT  = 16;
  localparam int SP_SEL_W    = 4;
  localparam int SAMPLE_W    = 16;
  localparam int LANES_FLAT  = LANE_COUNT * LANE_W;
  localparam int SAMPLES_FLAT = CONV_COUNT * SAMPLE_CNT * SAMPLE_W;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_CTRL = 12'h31e;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B0   = 12'h31f;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B1   = 12'h320;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B2   = 12'h321;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B3   = 12'h322;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B4   = 12'h323;
  localparam logic [ADDR_W-1:0] OFS_CHECK_CTRL   = 12'h32c;
  localparam logic [ADDR_W-1:0] OFS_EXPECT_LOW   = 12'h32d;
  localparam logic [ADDR_W-1:0] OFS_EXPECT_HIGH  = 12'h32e;
  localparam logic [ADDR_W-1:0] OFS_CHECK_STATUS = 12'h32f;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int POS_CAP_TRIGGER = 0;
  localparam int POS_CAP_SOURCE  = 1;
  localparam int POS_CAP_LANE    = 2;
  localparam int POS_CHK_ENABLE  = 0;
  localparam int POS_CHK_CLEAR   = 1;
  localparam int POS_CHK_CONV    = 2;
  localparam int POS_CHK_SAMPLE  = 4;
  localparam int POS_CHK_FLAG    = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_CAPTURE_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_CHECK_CTRL   = 8'h00;
  localparam logic [DATA_W-1:0] RST_EXPECT       = 8'h00;
  localparam logic [LANE_W-1:0] RST_CAPTURE      = 40'h00_0000_0000;
  localparam logic [DATA_W-1:0] RD_ZERO          = 8'h00;

  // bit offset of a lane inside the flat lane bus
  function automatic logic [8:0] lane_base(input logic [2:0] lane);
    lane_base = 9'(lane) * 9'd40;
  endfunction : lane_base

endpackage : lane_check_pkg

// [core/lane_snapshot.sv]
/*
 * lane snapshot: picks one receive lane and stores its word on a
 * trigger event.
 * assumes lane data and bit error come from the same clock domain.
 */
`timescale 1ns/1ps
module lane_snapshot (
  input  wire logic                                  clk_sys,     // clock
  input  wire logic                                  arst_n,      // reset
  input  wire logic [lane_check_pkg::LANES_FLAT-1:0] lane_data,   // lanes
  input  wire logic [lane_check_pkg::LANE_SEL_W-1:0] lane_select, // lane
  input  wire logic                                  trigger,     // sw bit
  input  wire logic                                  source,      // mode
  input  wire logic                                  bit_error,   // error
  output logic      [lane_check_pkg::LANE_W-1:0]     captured_r   // word
);

  logic [lane_check_pkg::LANE_W-1:0] sel_word;
  logic [lane_check_pkg::LANE_W-1:0] captured_nxt;
  logic                              trig_prev_r;
  logic                              trig_prev_nxt;
  logic                              grab;

  // ****************************************************************
  // trigger and capture
  // ****************************************************************
  always_comb
  begin
    // R09: lane select
    sel_word = lane_data[lane_check_pkg::lane_base(lane_select) +:
                         lane_check_pkg::LANE_W];
    trig_prev_nxt = trigger;
    // R10: trigger source
    // R01: rising trigger edge
    grab = source ? bit_error : (trigger & ~trig_prev_r);
    captured_nxt = grab ? sel_word : captured_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // R08: snapshot reset
      captured_r  <= lane_check_pkg::RST_CAPTURE;
      trig_prev_r <= 1'b0;
    end
    else
    begin
      captured_r  <= captured_nxt;
      trig_prev_r <= trig_prev_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sw_capture: assert property (  // R01
    @(posedge clk_sys) disable iff (!arst_n)
    (!source && trigger && !trig_prev_r) |=>
      captured_r == $past(sel_word))
    else $error("software trigger edge did not capture lane");

  a_err_capture: assert property (  // R10
    @(posedge clk_sys) disable iff (!arst_n)
    (source && bit_error) |=> captured_r == $past(sel_word))
    else $error("bit error did not capture lane");

  a_snap_hold: assert property (  // R10
    @(posedge clk_sys) disable iff (!arst_n)
    (source ? !bit_error : !(trigger && !trig_prev_r)) |=>
      $stable(captured_r))
    else $error("snapshot changed without trigger");

  c_sw_capture: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    !source && trigger && !trig_prev_r);

  c_err_capture: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    source && bit_error);

endmodule : lane_snapshot

// [core/sample_compare.sv]
/*
 * sample compare: picks one sample of one converter and compares it
 * with the expected value, keeping a sticky mismatch flag.
 * assumes samples and valid come from the receive link clock domain.
 */
`timescale 1ns/1ps
module sample_compare (
  input  wire logic                                    clk_sys,    // clock
  input  wire logic                                    arst_n,     // reset
  input  wire logic [lane_check_pkg::SAMPLES_FLAT-1:0] samples,    // data
  input  wire logic                                    valid,      // strobe
  input  wire logic [lane_check_pkg::SP_SEL_W-1:0]     sample_sel, // index
  input  wire logic [lane_check_pkg::CONV_SEL_W-1:0]   conv_sel,   // conv
  input  wire logic [lane_check_pkg::SAMPLE_W-1:0]     expected,   // ref
  input  wire logic                                    enable,     // run
  input  wire logic                                    clear,      // clear
  output logic                                         mismatch_r  // flag
);

  logic [9:0]                          sample_base;
  logic [lane_check_pkg::SAMPLE_W-1:0] sample;
  logic                                differs;
  logic                                mismatch_nxt;

  // ****************************************************************
  // compare and sticky flag
  // ****************************************************************
  always_comb
  begin
    // R03: sample index
    // R04: converter select
    sample_base = {conv_sel, sample_sel, 4'h0};
    sample      = samples[sample_base +: lane_check_pkg::SAMPLE_W];
    // R06: check enable
    differs     = enable && valid && (sample != expected);
    // R05: clear wins
    // R13: sticky flag
    if (clear)
      mismatch_nxt = 1'b0;
    else if (differs)
      mismatch_nxt = 1'b1;
    else
      mismatch_nxt = mismatch_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      mismatch_r <= 1'b0;
    else
      mismatch_r <= mismatch_nxt;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_clear_flag: assert property (  // R05
    @(posedge clk_sys) disable iff (!arst_n)
    clear |=> !mismatch_r)
    else $error("clear did not reset mismatch flag");

  a_set_on_diff: assert property (  // R12
    @(posedge clk_sys) disable iff (!arst_n)
    (enable && valid && !clear &&
     samples[{conv_sel, sample_sel, 4'h0} +: 16] != expected) |=>
      mismatch_r)
    else $error("mismatch not flagged");

  a_flag_sticky: assert property (  // R13
    @(posedge clk_sys) disable iff (!arst_n)
    (mismatch_r && !clear) |=> mismatch_r)
    else $error("mismatch flag dropped without clear");

  a_disabled_idle: assert property (  // R06
    @(posedge clk_sys) disable iff (!arst_n)
    (!enable && !mismatch_r) |=> !mismatch_r)
    else $error("flag set while check disabled");

  c_flag_set: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(mismatch_r));

  c_flag_clear: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    $fell(mismatch_r));

endmodule : sample_compare

// [core/serial_lane_capture_and_sample_check.sv]
/*
 * top of the lane capture and sample check block: byte register file,
 * registered read port, lane snapshot and sample compare.
 * assumes a register master on clk_sys giving one-cycle write and read
 * strobes, and lane and sample data from the same clock domain.
 */
`timescale 1ns/1ps
module serial_lane_capture_and_sample_check (
  input  wire logic                                    clk_sys,    // 50 MHz
  input  wire logic                                    arst_n,     // reset
  input  wire logic [lane_check_pkg::ADDR_W-1:0]       reg_addr,   // offset
  input  wire logic                                    reg_wr,     // write
  input  wire logic                                    reg_rd,     // read
  input  wire logic [lane_check_pkg::DATA_W-1:0]       reg_wdata,  // wdata
  output logic      [lane_check_pkg::DATA_W-1:0]       reg_rdata,  // rdata
  output logic                                         reg_rvalid, // rvalid
  input  wire logic [lane_check_pkg::LANES_FLAT-1:0]   lane_data,  // lanes
  input  wire logic                                    bit_error,  // error
  input  wire logic [lane_check_pkg::SAMPLES_FLAT-1:0] tpl_sample, // samples
  input  wire logic                                    tpl_valid   // strobe
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [lane_check_pkg::DATA_W-1:0] capture_ctrl_r;
  logic [lane_check_pkg::DATA_W-1:0] capture_ctrl_nxt;
  logic [lane_check_pkg::DATA_W-1:0] check_ctrl_r;
  logic [lane_check_pkg::DATA_W-1:0] check_ctrl_nxt;
  logic [lane_check_pkg::DATA_W-1:0] expect_low_r;
  logic [lane_check_pkg::DATA_W-1:0] expect_low_nxt;
  logic [lane_check_pkg::DATA_W-1:0] expect_high_r;
  logic [lane_check_pkg::DATA_W-1:0] expect_high_nxt;
  logic [lane_check_pkg::DATA_W-1:0] rdata_r;
  logic [lane_check_pkg::DATA_W-1:0] rdata_nxt;
  logic                              rvalid_r;
  logic                              rvalid_nxt;

  logic [lane_check_pkg::LANE_W-1:0]     captured_lane_word;
  logic                                  check_mismatch_flag;
  logic [lane_check_pkg::LANE_SEL_W-1:0] capture_lane_select;
  logic                                  capture_trigger;
  logic                                  capture_trigger_source;
  logic [lane_check_pkg::SP_SEL_W-1:0]   sample_index_select;
  logic [lane_check_pkg::CONV_SEL_W-1:0] converter_select;
  logic                                  check_clear;
  logic                                  check_enable;
  logic [lane_check_pkg::SAMPLE_W-1:0]   expected_sample;

  // ****************************************************************
  // field decode
  // ****************************************************************
  always_comb
  begin
    capture_trigger        = capture_ctrl_r[lane_check_pkg::POS_CAP_TRIGGER];
    capture_trigger_source = capture_ctrl_r[lane_check_pkg::POS_CAP_SOURCE];
    capture_lane_select    =
      capture_ctrl_r[lane_check_pkg::POS_CAP_LANE +: 3];
    check_enable           = check_ctrl_r[lane_check_pkg::POS_CHK_ENABLE];
    check_clear            = check_ctrl_r[lane_check_pkg::POS_CHK_CLEAR];
    converter_select       = check_ctrl_r[lane_check_pkg::POS_CHK_CONV +: 2];
    sample_index_select    =
      check_ctrl_r[lane_check_pkg::POS_CHK_SAMPLE +: 4];
    // R11: reference high byte
    expected_sample        = {expect_high_r, expect_low_r};
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_comb
  begin
    capture_ctrl_nxt = capture_ctrl_r;
    check_ctrl_nxt   = check_ctrl_r;
    expect_low_nxt   = expect_low_r;
    expect_high_nxt  = expect_high_r;
    if (reg_wr)
    begin
      case (reg_addr)
        lane_check_pkg::OFS_CAPTURE_CTRL:
          // reserved bits 7:5 are not stored
          capture_ctrl_nxt = {3'h0, reg_wdata[4:0]};
        lane_check_pkg::OFS_CHECK_CTRL:
          check_ctrl_nxt = reg_wdata;
        // R07: reference low byte
        lane_check_pkg::OFS_EXPECT_LOW:
          expect_low_nxt = reg_wdata;
        lane_check_pkg::OFS_EXPECT_HIGH:
          expect_high_nxt = reg_wdata;
        default:
          capture_ctrl_nxt = capture_ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // R08: control reset zero
      capture_ctrl_r <= lane_check_pkg::RST_CAPTURE_CTRL;
      check_ctrl_r   <= lane_check_pkg::RST_CHECK_CTRL;
      expect_low_r   <= lane_check_pkg::RST_EXPECT;
      expect_high_r  <= lane_check_pkg::RST_EXPECT;
    end
    else
    begin
      capture_ctrl_r <= capture_ctrl_nxt;
      check_ctrl_r   <= check_ctrl_nxt;
      expect_low_r   <= expect_low_nxt;
      expect_high_r  <= expect_high_nxt;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb
  begin
    rvalid_nxt = reg_rd;
    rdata_nxt  = lane_check_pkg::RD_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        lane_check_pkg::OFS_CAPTURE_CTRL:
          rdata_nxt = capture_ctrl_r;
        // R02: snapshot bytes low first
        lane_check_pkg::OFS_CAPTURE_B0:
          rdata_nxt = captured_lane_word[7:0];
        lane_check_pkg::OFS_CAPTURE_B1:
          rdata_nxt = captured_lane_word[15:8];
        lane_check_pkg::OFS_CAPTURE_B2:
          rdata_nxt = captured_lane_word[23:16];
        lane_check_pkg::OFS_CAPTURE_B3:
          rdata_nxt = captured_lane_word[31:24];
        lane_check_pkg::OFS_CAPTURE_B4:
          rdata_nxt = captured_lane_word[39:32];
        lane_check_pkg::OFS_CHECK_CTRL:
          rdata_nxt = check_ctrl_r;
        lane_check_pkg::OFS_EXPECT_LOW:
          rdata_nxt = expect_low_r;
        lane_check_pkg::OFS_EXPECT_HIGH:
          rdata_nxt = expect_high_r;
        // R12: mismatch flag read
        lane_check_pkg::OFS_CHECK_STATUS:
          rdata_nxt = {7'h00, check_mismatch_flag};
        default:
          rdata_nxt = lane_check_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_r  <= lane_check_pkg::RD_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ****************************************************************
  // datapath
  // ****************************************************************
  lane_snapshot u_snapshot (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .lane_data   (lane_data),
    .lane_select (capture_lane_select),
    .trigger     (capture_trigger),
    .source      (capture_trigger_source),
    .bit_error   (bit_error),
    .captured_r  (captured_lane_word)
  );

  sample_compare u_compare (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .samples    (tpl_sample),
    .valid      (tpl_valid),
    .sample_sel (sample_index_select),
    .conv_sel   (converter_select),
    .expected   (expected_sample),
    .enable     (check_enable),
    .clear      (check_clear),
    .mismatch_r (check_mismatch_flag)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  a_read_top_byte: assert property (  // R02
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == lane_check_pkg::OFS_CAPTURE_B4) |=>
      (reg_rvalid && reg_rdata == $past(captured_lane_word[39:32])))
    else $error("top snapshot byte read wrong");

  a_read_low_byte: assert property (  // R02
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == lane_check_pkg::OFS_CAPTURE_B0) |=>
      reg_rdata == $past(captured_lane_word[7:0]))
    else $error("low snapshot byte read wrong");

  a_snap_read_only: assert property (  // R02
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CAPTURE_B2 &&
     !bit_error && !capture_trigger && !capture_trigger_source) |=>
      $stable(captured_lane_word))
    else $error("snapshot changed by a write");

  a_flag_read: assert property (  // R12
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == lane_check_pkg::OFS_CHECK_STATUS) |=>
      reg_rdata == {7'h00, $past(check_mismatch_flag)})
    else $error("status read does not show mismatch flag");

  a_check_ctrl_wr: assert property (  // R03
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CHECK_CTRL) |=>
      (sample_index_select == $past(reg_wdata[7:4]) &&
       converter_select == $past(reg_wdata[3:2])))
    else $error("check control fields not stored");

  a_expect_wr: assert property (  // R07
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_EXPECT_LOW) ##1 !reg_wr ##1
    (reg_wr && reg_addr == lane_check_pkg::OFS_EXPECT_HIGH) |=>
      expected_sample == {$past(reg_wdata), $past(reg_wdata, 3)})
    else $error("expected sample bytes not assembled");

  a_lane_sel_wr: assert property (  // R09
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CAPTURE_CTRL) |=>
      (capture_lane_select == $past(reg_wdata[4:2]) &&
       reg_rvalid == $past(reg_rd)))
    else $error("lane select not stored");

  a_idle_read: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> (!reg_rvalid && reg_rdata == 8'h00))
    else $error("read data present without read");

  a_read_answer: assert property (  // R02
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");

  a_mid_byte_read: assert property (  // R02
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == lane_check_pkg::OFS_CAPTURE_B2) |=>
      reg_rdata == $past(captured_lane_word[23:16]))
    else $error("middle snapshot byte read wrong");

  a_ctrl_flags_wr: assert property (  // R06
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CHECK_CTRL) |=>
      (check_enable == $past(reg_wdata[0]) &&
       check_clear == $past(reg_wdata[1])))
    else $error("check enable or clear not stored");

  a_low_ref_wr: assert property (  // R07
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_EXPECT_LOW) |=>
      expect_low_r == $past(reg_wdata))
    else $error("reference low byte not stored");

  a_high_ref_wr: assert property (  // R11
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_EXPECT_HIGH) |=>
      expect_high_r == $past(reg_wdata))
    else $error("reference high byte not stored");

  a_ctrl_hold: assert property (  // R07
    @(posedge clk_sys) disable iff (!arst_n)
    !reg_wr |=> ($stable(check_ctrl_r) && $stable(expected_sample) &&
                 $stable(capture_ctrl_r)))
    else $error("register changed without write");

  a_src_trig_wr: assert property (  // R10
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CAPTURE_CTRL) |=>
      (capture_trigger_source == $past(reg_wdata[1]) &&
       capture_trigger == $past(reg_wdata[0])))
    else $error("capture source or trigger not stored");

  a_reserved_zero: assert property (  // R09
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == lane_check_pkg::OFS_CAPTURE_CTRL) |=>
      capture_ctrl_r[7:5] == 3'h0)
    else $error("reserved capture control bits stored");

  c_read_snapshot: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == lane_check_pkg::OFS_CAPTURE_B4 ##1 reg_rvalid);

endmodule : serial_lane_capture_and_sample_check

// [test/lane_source_model.sv]
/*
 * lane source model: far-side transmitter giving lane words and
 * receiver output samples.
 * assumes the bench moves the lane seed on clk_sys rising edges.
 */
`timescale 1ns/1ps
module lane_source_model (
  input  wire logic [39:0]   pattern,   // lane seed
  output logic      [319:0]  lane_data, // lanes
  output logic      [1023:0] tpl_sample // samples
);
  // ****************************************************************
  // lane n is seed plus n; sample c,s is {c, s, 5a}
  // ****************************************************************
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      lane_data[n*40 +: 40] = pattern + 40'(n);
    end
    for (int k = 0; k < 64; k++)
    begin
      tpl_sample[k*16 +: 16] = {4'(k / 16), 4'(k % 16), 8'h5a};
    end
  end
endmodule : lane_source_model

// [test/serial_lane_capture_and_sample_check_tb_top.sv]
/*
 * testbench for the lane capture and sample check block.
 * assumes the one-cycle strobe register port and the source model.
 */
`timescale 1ns/1ps
module serial_lane_capture_and_sample_check_tb_top;
  logic          clk_sys;
  logic          arst_n;
  logic [11:0]   reg_addr;
  logic          reg_wr;
  logic          reg_rd;
  logic [7:0]    reg_wdata;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  logic [319:0]  lane_data;
  logic          bit_error;
  logic [1023:0] tpl_sample;
  logic          tpl_valid;
  logic [39:0]   pattern;
  int            failures;
  int            num_checks;

  serial_lane_capture_and_sample_check u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lane_data(lane_data), .bit_error(bit_error),
    .tpl_sample(tpl_sample), .tpl_valid(tpl_valid));
  lane_source_model u_src (
    .pattern(pattern), .lane_data(lane_data), .tpl_sample(tpl_sample));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    check("rvalid", 40'(reg_rvalid), 40'h1);
    check($sformatf("rdata at %h", a), 40'(reg_rdata), 40'(exp));
  endtask : rd

  task automatic rd_word(input logic [39:0] exp);
    for (int b = 0; b < 5; b++)
    begin
      rd(12'h31f + 12'(b), exp[b*8 +: 8]);
    end
  endtask : rd_word

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    failures   = 0;
    num_checks = 0;
    arst_n     = 1'b0;
    reg_addr   = 12'h000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 8'h00;
    bit_error  = 1'b0;
    tpl_valid  = 1'b0;
    pattern    = 40'h12_3456_789a;
    repeat (8) @(posedge clk_sys);
    arst_n    <= 1'b1;
    tpl_valid <= 1'b1;
    rd_word(40'h00_0000_0000);
    rd(12'h32c, 8'h00);
    rd(12'h32d, 8'h00);
    rd(12'h32e, 8'h00);
    wr(12'h321, 8'hff);
    rd(12'h321, 8'h00);
    // each lane in turn, trigger lowered before the next rise
    for (int n = 0; n < 8; n++)
    begin
      wr(12'h31e, {3'b000, 3'(n), 2'b01});
      wr(12'h31e, 8'h00);
      rd_word(pattern + 40'(n));
      @(posedge clk_sys);
      pattern <= pattern ^ 40'hff_00ff_0f0f;
    end
    // rise captures lane 0, then the held level must not capture again
    wr(12'h31e, 8'h01);
    @(posedge clk_sys);
    pattern <= 40'hc3_c3c3_3c3c;
    rd_word(40'h12_3456_789a);
    // error-triggered capture on lane 5
    wr(12'h31e, {3'b000, 3'd5, 2'b10});
    @(posedge clk_sys);
    pattern   <= 40'h5a_0f1e_2d3c;
    bit_error <= 1'b1;
    @(posedge clk_sys);
    bit_error <= 1'b0;
    rd_word(40'h5a_0f1e_2d41);
    wr(12'h31e, 8'hff);
    rd(12'h31e, 8'h1f);
    // every sample index, converters cycling
    for (int k = 0; k < 16; k++)
    begin
      wr(12'h32c, 8'h02);
      wr(12'h32d, 8'h5a);
      wr(12'h32e, {4'(k % 4), 4'(k)});
      wr(12'h32c, {4'(k), 2'(k % 4), 2'b01});
      rd(12'h32f, 8'h00);
    end
    wr(12'h32d, 8'h5b);
    rd(12'h32f, 8'h01);
    wr(12'h32d, 8'h5a);
    rd(12'h32f, 8'h01);
    wr(12'h32c, 8'hff);
    rd(12'h32f, 8'h00);
    wr(12'h32c, 8'hfc);
    wr(12'h32d, 8'h5b);
    rd(12'h32f, 8'h00);
    rd(12'h32c, 8'hfc);
    rd(12'h32d, 8'h5b);
    // reset in mid-run clears the snapshot, check control and high reference registers
    arst_n <= 1'b0;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rd_word(40'h00_0000_0000);
    rd(12'h32c, 8'h00);
    rd(12'h32e, 8'h00);
    tally_and_finish();
  end
endmodule : serial_lane_capture_and_sample_check_tb_top
